// [hw/adc_out_pkg.sv]
package adc_out_pkg;

   localparam int WORD_W = 12;

   // Four-level static pins are presented as two-bit level codes.
   localparam logic [1:0] LVL_0   = 2'h0;
   localparam logic [1:0] LVL_1_3 = 2'h1;
   localparam logic [1:0] LVL_2_3 = 2'h2;
   localparam logic [1:0] LVL_TOP = 2'h3;

   localparam int PIPE_STAGES = 5;

   // Register map, byte addresses.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_IRQ     = 8'h08;
   localparam logic [7:0] ADDR_MASK    = 8'h0C;
   localparam logic [7:0] ADDR_SAMPLE  = 8'h10;
   localparam logic [7:0] ADDR_COUNT   = 8'h14;

   // Control register fields.
   localparam int CTRL_PD_BIT   = 0;
   localparam int CTRL_OEN_BIT  = 1;
   localparam int CTRL_STY_LSB  = 4;
   localparam int CTRL_FMT_LSB  = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

   // Interrupt bits.
   localparam int IRQ_SAMPLE_BIT = 0;
   localparam int IRQ_RANGE_BIT  = 1;
   localparam int IRQ_W          = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [3:0] {
      PWR_NORMAL = 4'h1,
      PWR_HIZ    = 4'h2,
      PWR_NAP    = 4'h4,
      PWR_SLEEP  = 4'h8
   } pwr_state_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic              range;
   } sample_t;

   typedef struct packed {
      sample_t first;
      logic    first_strobe;
      sample_t second;
      logic    second_strobe;
      logic    bus_oe_n;
      logic    second_oe_n;
      logic    second_strobe_oe_n;
      logic    diff_oe_n;
   } out_pins_t;

endpackage

// [hw/adc_output_interface.sv]
`timescale 1ns/1ps
// Summary of operation
// R1 - Power-down low converts normally; outputs drive only while drive enable is low.
// R2 - Power-down high naps with enable low, sleeps with it high; outputs high impedance.
// R3 - Style select picks full-rate, demux simultaneous, demux interleaved or differential.
// R4 - Format select sets offset binary or two's complement and stabilizer on or off.
// R5 - Each conversion starts on the rising edge of the positive sample strobe.
// R6 - Sample words are 12 bits, bit 11 most significant.
// R7 - Full-rate style holds second bus word and range flag at high impedance.
// R8 - Second bus valid strobe stays driven in full-rate style.
// R9 - Receiver latches second bus on strobe fall interleaved, rise simultaneous.
// R10 - Receiver latches first bus on falling edge of its valid strobe.
// R11 - Receiver latches differential data on falling edge of positive strobe leg.
// R12 - Range flag is high with any over- or under-ranged sample, else low.
// R13 - Two's complement just below midscale is all ones, just above all zeros.
// R14 - Result appears five sample-strobe cycles after the sample is taken; in demux simultaneous style the first bus word appears after six.
// R15 - Demux styles alternate samples between buses, each updating at half rate.
// R16 - Full-rate style puts every sample on the first bus, strobe toggles each sample.
module adc_output_interface #(
   parameter int WORD_W      = adc_out_pkg::WORD_W,
   parameter int PIPE_STAGES = adc_out_pkg::PIPE_STAGES
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              clk_en,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              sample_strobe_pos,
   input  wire logic              sample_strobe_neg,
   input  wire logic [WORD_W-1:0] analog_code,
   input  wire logic              analog_over_range,
   output logic [WORD_W-1:0]      first_bus_word,
   output logic                   first_bus_range_flag,
   output logic                   first_bus_valid_strobe,
   output logic [WORD_W-1:0]      second_bus_word,
   output logic                   second_bus_range_flag,
   output logic                   second_bus_valid_strobe,
   output logic [WORD_W-1:0]      diff_sample_word,
   output logic                   diff_range_flag,
   output logic                   diff_valid_strobe,
   output logic                   first_bus_oe_n,
   output logic                   second_bus_oe_n,
   output logic                   second_strobe_oe_n,
   output logic                   diff_oe_n,
   output logic                   stabilizer_on,
   output logic                   irq
);

   // Control fields stand in for the static pins.
   logic [31:0]       ctrl;
   logic [adc_out_pkg::IRQ_W-1:0] irq_status;
   logic [adc_out_pkg::IRQ_W-1:0] irq_mask;
   logic [31:0]       sample_count;

   logic              power_down_select;
   logic              output_drive_enable_n;
   logic [1:0]        output_style_select;
   logic [1:0]        format_stabilizer_select;

   adc_out_pkg::pwr_state_t pwr_state;
   adc_out_pkg::pwr_state_t next_pwr_state;

   // The sample strobe pair arrives from another domain.
   // A strobe high at release counts as a rise.
   logic [1:0]        pos_sync;
   logic [1:0]        neg_sync;
   logic              pos_prev;

   logic              sample_edge;

   // Stage words and range flags.
   logic [WORD_W-1:0] code_pipe [PIPE_STAGES];
   logic              range_pipe [PIPE_STAGES];

   logic              pipe_out_valid;
   logic [PIPE_STAGES-1:0] valid_pipe;

   // Demux pairing state.
   logic              bus_sel;
   adc_out_pkg::sample_t held_first;

   // Address phase kept for the data phase.
   logic              ap_valid;
   logic              ap_write;
   logic [7:0]        ap_addr;

   function automatic logic [WORD_W-1:0] format_code(input logic [WORD_W-1:0] code,
                                                     input logic [1:0] fmt);
      // Offset binary to two's complement is an inverted most significant bit.
      if (fmt == adc_out_pkg::LVL_2_3 || fmt == adc_out_pkg::LVL_TOP) begin
         format_code = {~code[WORD_W-1], code[WORD_W-2:0]}; // R13
      end else begin
         format_code = code;
      end
   endfunction

   assign power_down_select        = ctrl[adc_out_pkg::CTRL_PD_BIT];
   assign output_drive_enable_n    = ctrl[adc_out_pkg::CTRL_OEN_BIT];
   assign output_style_select      = ctrl[adc_out_pkg::CTRL_STY_LSB +: 2];
   assign format_stabilizer_select = ctrl[adc_out_pkg::CTRL_FMT_LSB +: 2];

   // Strobe synchroniser; only the second stage and its delayed copy pos_prev feed logic.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_sync <= 2'h0;
         neg_sync <= 2'h3;
         pos_prev <= 1'b0;
      end else if (clk_en) begin
         pos_sync <= {pos_sync[0], sample_strobe_pos};
         neg_sync <= {neg_sync[0], sample_strobe_neg};
         pos_prev <= pos_sync[1];
      end
   end

   // A differential rise is positive above negative, taken from low to high.
   assign sample_edge = (pos_sync[1] & ~neg_sync[1]) & ~pos_prev; // R5

   // Four power states from two controls.
   always_comb begin
      case ({power_down_select, output_drive_enable_n})
         2'b00:   next_pwr_state = adc_out_pkg::PWR_NORMAL; // R1
         2'b01:   next_pwr_state = adc_out_pkg::PWR_HIZ;    // R1
         2'b10:   next_pwr_state = adc_out_pkg::PWR_NAP;    // R2
         2'b11:   next_pwr_state = adc_out_pkg::PWR_SLEEP;  // R2
         default: next_pwr_state = adc_out_pkg::PWR_SLEEP;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_state <= adc_out_pkg::PWR_HIZ;
      end else if (clk_en) begin
         pwr_state <= next_pwr_state;
      end
   end

   // Conversion pipeline: five stages, stopped while powered down.
   // A frozen pipeline keeps its words across a nap.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < PIPE_STAGES; i++) begin
            code_pipe[i]  <= '0;
            range_pipe[i] <= 1'b0;
         end
         valid_pipe <= '0;
      end else if (clk_en && sample_edge && !power_down_select) begin
         code_pipe[0]  <= analog_code;       // R6
         range_pipe[0] <= analog_over_range; // R12
         valid_pipe    <= {valid_pipe[PIPE_STAGES-2:0], 1'b1};
         for (int i = 1; i < PIPE_STAGES; i++) begin
            code_pipe[i]  <= code_pipe[i-1];  // R14
            range_pipe[i] <= range_pipe[i-1];
         end
      end
   end

   assign pipe_out_valid = valid_pipe[PIPE_STAGES-1];

   // Output stage updates on each strobe edge, one pipeline word per edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_bus_word          <= '0;
         first_bus_range_flag    <= 1'b0;
         first_bus_valid_strobe  <= 1'b0;
         second_bus_word         <= '0;
         second_bus_range_flag   <= 1'b0;
         second_bus_valid_strobe <= 1'b0;
         diff_sample_word        <= '0;
         diff_range_flag         <= 1'b0;
         diff_valid_strobe       <= 1'b0;
         bus_sel                 <= 1'b0;
         held_first              <= '0;
      end else if (clk_en && sample_edge && !power_down_select && pipe_out_valid) begin
         case (output_style_select) // R3
            adc_out_pkg::LVL_0: begin
               // Second strobe runs though its bus floats.
               first_bus_word         <= format_code(code_pipe[PIPE_STAGES-1],
                                                     format_stabilizer_select); // R16
               first_bus_range_flag   <= range_pipe[PIPE_STAGES-1]; // R12
               first_bus_valid_strobe <= ~first_bus_valid_strobe;   // R16
               second_bus_valid_strobe <= ~second_bus_valid_strobe; // R8
            end
            adc_out_pkg::LVL_1_3: begin
               bus_sel <= ~bus_sel; // R15
               if (!bus_sel) begin
                  held_first.word  <= format_code(code_pipe[PIPE_STAGES-1],
                                                  format_stabilizer_select);
                  held_first.range <= range_pipe[PIPE_STAGES-1];
               end else begin
                  // Both buses move together on the second sample of a pair.
                  first_bus_word          <= held_first.word;
                  first_bus_range_flag    <= held_first.range;
                  second_bus_word         <= format_code(code_pipe[PIPE_STAGES-1],
                                                         format_stabilizer_select);
                  second_bus_range_flag   <= range_pipe[PIPE_STAGES-1];
                  first_bus_valid_strobe  <= ~first_bus_valid_strobe;  // R15
                  second_bus_valid_strobe <= ~second_bus_valid_strobe; // R15
               end
            end
            adc_out_pkg::LVL_2_3: begin
               // Even samples go first, odd ones second.
               bus_sel <= ~bus_sel; // R15
               if (!bus_sel) begin
                  first_bus_word         <= format_code(code_pipe[PIPE_STAGES-1],
                                                        format_stabilizer_select);
                  first_bus_range_flag   <= range_pipe[PIPE_STAGES-1];
                  first_bus_valid_strobe <= ~first_bus_valid_strobe; // R15
               end else begin
                  second_bus_word         <= format_code(code_pipe[PIPE_STAGES-1],
                                                         format_stabilizer_select);
                  second_bus_range_flag   <= range_pipe[PIPE_STAGES-1];
                  second_bus_valid_strobe <= ~second_bus_valid_strobe; // R15
               end
            end
            default: begin
               // Differential style has its own strobe.
               diff_sample_word  <= format_code(code_pipe[PIPE_STAGES-1],
                                                format_stabilizer_select);
               diff_range_flag   <= range_pipe[PIPE_STAGES-1]; // R12
               diff_valid_strobe <= ~diff_valid_strobe;
            end
         endcase
      end
   end

   // Output enables are active low; everything floats outside normal drive.
   // Enables follow a control write one edge later.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_bus_oe_n     <= 1'b1;
         second_bus_oe_n    <= 1'b1;
         second_strobe_oe_n <= 1'b1;
         diff_oe_n          <= 1'b1;
         stabilizer_on      <= 1'b0;
      end else if (clk_en) begin
         if (next_pwr_state == adc_out_pkg::PWR_NORMAL) begin // R1 R2
            first_bus_oe_n     <= (output_style_select == adc_out_pkg::LVL_TOP);
            second_bus_oe_n    <= (output_style_select == adc_out_pkg::LVL_TOP) ||
                                  (output_style_select == adc_out_pkg::LVL_0); // R7
            second_strobe_oe_n <= (output_style_select == adc_out_pkg::LVL_TOP); // R8
            diff_oe_n          <= (output_style_select != adc_out_pkg::LVL_TOP);
         end else begin
            first_bus_oe_n     <= 1'b1;
            second_bus_oe_n    <= 1'b1;
            second_strobe_oe_n <= 1'b1;
            diff_oe_n          <= 1'b1;
         end
         stabilizer_on <= (format_stabilizer_select == adc_out_pkg::LVL_1_3) ||
                          (format_stabilizer_select == adc_out_pkg::LVL_2_3); // R4
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 8'h00;
      end else if (clk_en && hready) begin
         ap_valid <= hsel && (htrans == adc_out_pkg::HTRANS_NONSEQ);
         ap_write <= hwrite;
         ap_addr  <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl     <= adc_out_pkg::CTRL_RESET;
         irq_mask <= '0;
      end else if (clk_en && ap_valid && ap_write) begin
         // Writes land while hwdata stands.
         if (ap_addr == adc_out_pkg::ADDR_CTRL) begin
            ctrl <= hwdata;
         end
         if (ap_addr == adc_out_pkg::ADDR_MASK) begin
            irq_mask <= hwdata[adc_out_pkg::IRQ_W-1:0];
         end
      end
   end

   // Events win over the read that clears them in the same cycle.
   // Clearing at the address phase loses no event to the read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status   <= '0;
         sample_count <= '0;
      end else if (clk_en) begin
         if (hsel && hready && htrans == adc_out_pkg::HTRANS_NONSEQ && !hwrite &&
             haddr[7:0] == adc_out_pkg::ADDR_IRQ) begin
            irq_status <= '0;
         end
         if (sample_edge && !power_down_select && pipe_out_valid) begin
            irq_status[adc_out_pkg::IRQ_SAMPLE_BIT] <= 1'b1;
            sample_count <= sample_count + 32'h0000_0001;
            if (range_pipe[PIPE_STAGES-1]) begin
               irq_status[adc_out_pkg::IRQ_RANGE_BIT] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         // Unmasked status bits drive the level.
         irq <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en) begin
         // Read data stands for one cycle.
         hrdata <= 32'h0000_0000;
         if (hsel && hready && htrans == adc_out_pkg::HTRANS_NONSEQ && !hwrite) begin
            case (haddr[7:0])
               adc_out_pkg::ADDR_CTRL:   hrdata <= ctrl;
               adc_out_pkg::ADDR_STATUS: hrdata <= {28'h0000000, pwr_state};
               adc_out_pkg::ADDR_IRQ:    hrdata <= {30'h00000000, irq_status};
               adc_out_pkg::ADDR_MASK:   hrdata <= {30'h00000000, irq_mask};
               adc_out_pkg::ADDR_SAMPLE: hrdata <= {19'h00000, first_bus_range_flag,
                                                    first_bus_word};
               adc_out_pkg::ADDR_COUNT:  hrdata <= sample_count;
               default:                  hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// [bench/adc_out_sva.sv]
`timescale 1ns/1ps
module adc_out_sva #(
   parameter int WORD_W = adc_out_pkg::WORD_W
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic [31:0]       hwdata,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [WORD_W-1:0] first_bus_word,
   input wire logic              first_bus_range_flag,
   input wire logic              first_bus_valid_strobe,
   input wire logic              diff_valid_strobe,
   input wire logic              first_bus_oe_n,
   input wire logic              second_bus_oe_n,
   input wire logic              second_strobe_oe_n,
   input wire logic              diff_oe_n,
   input wire logic              stabilizer_on
);
   logic        wr_ph;
   logic        rd_ph;
   logic [31:0] ctl;
   logic [1:0]  calm;
   wire         take = hsel && hready && htrans == adc_out_pkg::HTRANS_NONSEQ;
   // Pin checks wait until the shadow control word has been quiet for three edges.
   wire         ok = calm == 2'h3;
   wire         en = ctl[1:0] == 2'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         rd_ph <= 1'b0;
      end else begin
         wr_ph <= take && hwrite && haddr[7:0] == adc_out_pkg::ADDR_CTRL;
         rd_ph <= take && !hwrite;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ctl <= adc_out_pkg::CTRL_RESET;
      else if (wr_ph) ctl <= hwdata;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) calm <= 2'h3;
      else if (wr_ph) calm <= 2'h0;
      else if (calm != 2'h3) calm <= calm + 2'h1;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
   a_read_idle: assert property (!rd_ph |-> hrdata == 32'h0) else $error("stray read data");
   a_off_hiz: assert property (ok && !en |-> first_bus_oe_n && second_bus_oe_n &&
      second_strobe_oe_n && diff_oe_n) else $error("outputs driven while off");
   a_full_rate_pins: assert property (ok && en && ctl[5:4] == 2'h0 |->
      !first_bus_oe_n && second_bus_oe_n && !second_strobe_oe_n) else $error("full-rate pins");
   a_demux_pins: assert property (ok && en && ctl[5:4] inside {2'h1, 2'h2} |->
      !first_bus_oe_n && !second_bus_oe_n && !second_strobe_oe_n) else $error("demux pins");
   a_diff_pins: assert property (ok && en && ctl[5:4] == 2'h3 |-> !diff_oe_n)
      else $error("differential outputs not driven");
   a_stab_select: assert property (ok |-> stabilizer_on == (ctl[9:8] inside {2'h1, 2'h2}))
      else $error("stabilizer setting wrong");
   a_nap_frozen: assert property (ok && ctl[0] |=> $stable(first_bus_valid_strobe) &&
      $stable(diff_valid_strobe)) else $error("strobe moved while powered down");
   a_word_with_strobe: assert property (ok && ($changed(first_bus_word) ||
      $changed(first_bus_range_flag)) |-> $changed(first_bus_valid_strobe))
      else $error("word changed without strobe");
   a_strobe_gap: assert property ($changed(first_bus_valid_strobe) |=>
      !$changed(first_bus_valid_strobe) [*4]) else $error("strobe toggles too fast");
endmodule
bind adc_output_interface adc_out_sva #(.WORD_W(WORD_W)) i_adc_out_sva (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout,
   .hresp, .first_bus_word, .first_bus_range_flag, .first_bus_valid_strobe, .diff_valid_strobe,
   .first_bus_oe_n, .second_bus_oe_n, .second_strobe_oe_n, .diff_oe_n, .stabilizer_on);

// [bench/capture_receiver.sv]
`timescale 1ns/1ps
module capture_receiver (
   input  wire logic        hclk,
   input  wire logic [1:0]  style,
   input  wire logic [11:0] first_bus_word,
   input  wire logic        first_bus_valid_strobe,
   input  wire logic        first_bus_oe_n,
   input  wire logic [11:0] second_bus_word,
   input  wire logic        second_bus_valid_strobe,
   input  wire logic        second_bus_oe_n,
   input  wire logic [11:0] diff_sample_word,
   input  wire logic        diff_valid_strobe,
   input  wire logic        diff_oe_n,
   output int               n_caps
);
   logic        fq = 1'b0;
   logic        sq = 1'b0;
   logic        dq = 1'b0;
   logic [11:0] got_first;
   logic [11:0] got_second;
   logic [11:0] got_diff;
   // Edges are found on the fast clock, so the word latched is the one sent with the edge.
   always @(posedge hclk) begin
      if (fq && !first_bus_valid_strobe && !first_bus_oe_n) begin
         got_first = first_bus_word;
         n_caps++;
      end
      if (sq != second_bus_valid_strobe && !second_bus_oe_n &&
          second_bus_valid_strobe == (style == adc_out_pkg::LVL_1_3)) begin
         got_second = second_bus_word;
         n_caps++;
      end
      if (dq && !diff_valid_strobe && !diff_oe_n) begin
         got_diff = diff_sample_word;
         n_caps++;
      end
      fq = first_bus_valid_strobe;
      sq = second_bus_valid_strobe;
      dq = diff_valid_strobe;
   end
   initial n_caps = 0;
endmodule

// [bench/adc_output_interface_tb.sv]
`timescale 1ns/1ps
module adc_output_interface_tb;
   localparam int LAT = adc_out_pkg::PIPE_STAGES + 1;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic [1:0]  htrans = 2'h0, sty = 2'h0, fmt = 2'h0;
   logic        hreadyout, hresp, irq, stabilizer_on, cur_pd = 1'b0, chk_on = 1'b0;
   logic        sample_strobe_pos = 1'b0, analog_over_range = 1'b0, fq = 1'b0, sq = 1'b0;
   logic [11:0] analog_code = 12'h0, first_bus_word, second_bus_word, diff_sample_word;
   logic        first_bus_range_flag, first_bus_valid_strobe, second_bus_range_flag, dq = 1'b0;
   logic        second_bus_valid_strobe, diff_range_flag, diff_valid_strobe;
   logic        first_bus_oe_n, second_bus_oe_n, second_strobe_oe_n, diff_oe_n;
   wire         sample_strobe_neg = ~sample_strobe_pos;
   logic        clk_en = 1'b1;
   logic [3:0]  pwr [4] = '{4'h1, 4'h4, 4'h2, 4'h8};
   adc_out_pkg::sample_t smp[$];
   int          errors = 0, num_checks = 0, cnt = 0, n_caps, n0, i;
   adc_output_interface i_adc_output_interface (.hclk, .hresetn, .clk_en, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .sample_strobe_pos, .sample_strobe_neg, .analog_code, .analog_over_range,
      .first_bus_word, .first_bus_range_flag, .first_bus_valid_strobe, .second_bus_word,
      .second_bus_range_flag, .second_bus_valid_strobe, .diff_sample_word, .diff_range_flag,
      .diff_valid_strobe, .first_bus_oe_n, .second_bus_oe_n, .second_strobe_oe_n, .diff_oe_n,
      .stabilizer_on, .irq);
   capture_receiver i_capture_receiver (.hclk, .style(sty), .first_bus_word,
      .first_bus_valid_strobe, .first_bus_oe_n, .second_bus_word, .second_bus_valid_strobe,
      .second_bus_oe_n, .diff_sample_word, .diff_valid_strobe, .diff_oe_n, .n_caps);
   always #12.5 hclk = ~hclk;
   // The sample strobe is offset so its edges never line up with the bus clock.
   initial begin
      #7;
      forever #100 sample_strobe_pos = ~sample_strobe_pos;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= adc_out_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk("register", e, v);
   endtask
   // Control changes land mid-way between strobe rises so no sample is half counted.
   task automatic set_ctrl(input logic [31:0] v);
      logic [31:0] r;
      @(negedge sample_strobe_pos);
      @(posedge hclk);
      bus(1'b1, adc_out_pkg::ADDR_CTRL, v, r);
      cur_pd = v[0];
      sty = v[5:4];
      fmt = v[9:8];
   endtask
   function automatic logic [31:0] expect_at(input int k);
      adc_out_pkg::sample_t s;
      s = smp[k];
      if (fmt[1]) s.word[11] = ~s.word[11];
      return 32'(s);
   endfunction
   always @(posedge sample_strobe_pos) begin
      if (hresetn && !cur_pd) begin
         smp.push_back({analog_code, analog_over_range});
         cnt++;
      end
   end
   always @(negedge sample_strobe_pos) begin
      @(posedge hclk);
      analog_code <= (cnt % 16 == 3) ? 12'h7FF : (cnt % 16 == 4) ? 12'h800 : 12'($urandom);
      analog_over_range <= (cnt % 16 == 5) || ($urandom % 8 == 0);
   end
   always @(posedge hclk) begin
      if (chk_on && first_bus_valid_strobe !== fq && (sty == 2'h0 || sty == 2'h2))
         chk("first", expect_at(cnt - LAT), 32'({first_bus_word, first_bus_range_flag}));
      if (chk_on && second_bus_valid_strobe !== sq && (sty == 2'h1 || sty == 2'h2))
         chk("second", expect_at(cnt - LAT), 32'({second_bus_word, second_bus_range_flag}));
      if (chk_on && second_bus_valid_strobe !== sq && sty == 2'h1)
         chk("first", expect_at(cnt - LAT - 1), 32'({first_bus_word, first_bus_range_flag}));
      if (chk_on && diff_valid_strobe !== dq && sty == 2'h3)
         chk("diff", expect_at(cnt - LAT), 32'({diff_sample_word, diff_range_flag}));
      fq = first_bus_valid_strobe;
      sq = second_bus_valid_strobe;
      dq = diff_valid_strobe;
   end
   initial begin
      #300us;
      errors++;
      $display("ERROR watchdog expected finish seen timeout");
      tally_and_finish();
   end
   initial begin
      void'($urandom(25));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(adc_out_pkg::ADDR_CTRL, adc_out_pkg::CTRL_RESET);
      rd_chk(8'h40, 32'h0);
      for (i = 0; i < 4; i++) begin
         set_ctrl(32'(i));
         repeat (4) @(posedge hclk);
         rd_chk(adc_out_pkg::ADDR_STATUS, 32'(pwr[i]));
         chk("first_oe_n", 32'(i != 0), 32'(first_bus_oe_n));
      end
      for (i = 0; i < 4; i++) begin
         n0 = n_caps;
         set_ctrl(32'((i << 8) | (i << 4)));
         repeat (8) @(posedge sample_strobe_pos);
         chk_on = 1'b1;
         repeat (12) @(posedge sample_strobe_pos);
         chk_on = 1'b0;
         chk("stabilizer", 32'(i == 1 || i == 2), 32'(stabilizer_on));
         chk("captures", 32'h1, 32'(n_caps > n0));
      end
      bus(1'b1, adc_out_pkg::ADDR_MASK, 32'h3, d);
      repeat (3) @(posedge hclk);
      chk("irq", 32'h1, 32'(irq));
      set_ctrl(32'h1);
      repeat (8) @(posedge hclk);
      bus(1'b0, adc_out_pkg::ADDR_IRQ, 32'h0, d);
      chk("irq_status", 32'h3, 32'(d[1:0]));
      rd_chk(adc_out_pkg::ADDR_IRQ, 32'h0);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h0, 32'(irq));
      bus(1'b1, adc_out_pkg::ADDR_MASK, 32'h0, d);
      set_ctrl(32'h0);
      repeat (3) @(posedge sample_strobe_pos);
      repeat (8) @(posedge hclk);
      chk("irq_masked", 32'h0, 32'(irq));
      n0 = cnt;
      clk_en <= 1'b0;
      repeat (3) @(posedge sample_strobe_pos);
      @(posedge hclk);
      clk_en <= 1'b1;
      rd_chk(adc_out_pkg::ADDR_COUNT, 32'(n0 - adc_out_pkg::PIPE_STAGES));
      tally_and_finish();
   end
endmodule
